// [sfs_secondary_fault_status.sv]
// Secondary fault status register with frame length check.
// Assumes SPI pins and fault detector levels are synchronous to
// clock, and that a frame decoder presents its command in the cycle
// in which chip select is first seen high.
//
// How it works
// - Undervoltage flag bit 4 is one while supply A is below threshold.
// - Addressable mode frame is exactly 24 clocks with CRC, 16 without.
// - Daisy-chain frame is a whole multiple of 24 or 16 clocks.
// - Clock count error flag bit 3 sets on a frame breaking the length.
// - Command of a badly clocked frame is dropped without any effect.
// - Thermal shutdown bit 2 switches off channels, currents, LEDs, outputs, SPI.
// - Reference pin open flag bit 1 sets on open circuit.
// - Open reference pin only raises the flag, channels keep running.
// - Open flag reads one during thermal shutdown.
// - Short detection on bit 0 runs only while its enable is one.
// - With short detection off the short flag keeps its latched value.
// - Channels stay disabled while the reference pin short persists and short detection is on.
// - Summary fault is OR of all unmasked flags.
// - Reading the register clears its flags, the short flag only while its detection is on; summary follows.

`timescale 1ns/1ps
`default_nettype none

module sfs_secondary_fault_status
  import sfs_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // SPI pins, already in this clock domain
  input  wire logic                  spiSclk,
  input  wire logic                  spiCsN,
  // Frame mode straps and configuration
  input  wire logic                  daisyChain,
  input  wire logic                  crcEnable,
  input  wire logic                  shortDetectEnable,
  input  wire logic [SFS_FLAG_W-1:0] faultMask,
  // Command from the frame decoder
  input  wire logic                  cmdValid,
  input  wire logic                  cmdRead,
  input  wire logic [SFS_ADDR_W-1:0] cmdAddr,
  // Analog detector levels
  input  wire logic                  supplyAUnder,
  input  wire logic                  overTemp,
  input  wire logic                  refOpenDetect,
  input  wire logic                  refShortDetect,
  // Results
  output logic                       cmdAccept,
  output logic [SFS_REG_W-1:0]       flagsOut,
  output logic [SFS_REG_W-1:0]       readData,
  output logic                       summaryFault,
  output logic                       shutdownAll,
  output logic                       channelsDisable
);

  // Frame length per CRC setting
  function automatic logic [4:0] frameLen(input logic crcOn);
    frameLen = crcOn ? SFS_LEN_CRC : SFS_LEN_NOCRC;
  endfunction : frameLen

  // Edge history of the SPI pins
  logic sclkPrev_reg;
  logic sclkPrev_next;
  logic csPrev_reg;
  logic csPrev_next;

  // Frame clock counters
  logic [4:0] phase_reg;
  logic [4:0] phase_next;
  logic [1:0] groups_reg;
  logic [1:0] groups_next;

  // Flags and read capture
  logic [SFS_FLAG_W-1:0] flags_reg;
  logic [SFS_FLAG_W-1:0] flags_next;
  logic [SFS_REG_W-1:0]  rdata_reg;
  logic [SFS_REG_W-1:0]  rdata_next;

  logic sclkRise;
  logic csFall;
  logic frameEnd;
  logic countOk;
  logic readHit;
  logic [4:0] lenNow;
  logic [SFS_FLAG_W-1:0] setVec;
  logic [SFS_FLAG_W-1:0] clrVec;

  // Edge detection on the sampled pins
  always_comb begin
    sclkPrev_next = spiSclk;
    csPrev_next   = spiCsN;
    sclkRise      = spiSclk && !sclkPrev_reg;
    csFall        = !spiCsN && csPrev_reg;
    frameEnd      = spiCsN && !csPrev_reg;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclkPrev_reg <= 1'b0;
      csPrev_reg   <= 1'b1;
    end else begin
      sclkPrev_reg <= sclkPrev_next;
      csPrev_reg   <= csPrev_next;
    end
  end

  // Count clocks modulo the frame length, plus whole groups;
  // avoids a divider for the daisy-chain multiple check
  always_comb begin
    lenNow      = frameLen(crcEnable);
    phase_next  = phase_reg;
    groups_next = groups_reg;
    if (csFall) begin
      phase_next  = 5'h00;
      groups_next = 2'h0;
    end else if (!spiCsN && sclkRise) begin
      if (phase_reg == lenNow - 5'h01) begin
        phase_next = 5'h00;
        if (groups_reg != SFS_GROUP_MANY) begin
          groups_next = groups_reg + 2'h1;
        end
      end else begin
        phase_next = phase_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_reg  <= 5'h00;
      groups_reg <= 2'h0;
    end else begin
      phase_reg  <= phase_next;
      groups_reg <= groups_next;
    end
  end

  // Length verdict for the frame that just ended
  always_comb begin
    if (daisyChain) begin
      countOk = (phase_reg == 5'h00) && (groups_reg != 2'h0);
    end else begin
      countOk = (phase_reg == 5'h00) && (groups_reg == SFS_GROUP_ONE);
    end
  end

  // Command gate; SPI is dead in shutdown, so nothing passes then
  assign cmdAccept = cmdValid && frameEnd && countOk && !overTemp;
  assign readHit   = cmdAccept && cmdRead && (cmdAddr == SFS_FLAGS_OFFSET);

  // Flag update: sources set, a read clears, set wins over clear
  always_comb begin
    setVec = '0;
    clrVec = '0;
    setVec[SFS_BIT_UNDERV] = supplyAUnder;
    setVec[SFS_BIT_CLKERR] = frameEnd && !countOk && !overTemp;
    setVec[SFS_BIT_OTEMP]  = overTemp;
    setVec[SFS_BIT_OPEN]   = refOpenDetect || overTemp;
    setVec[SFS_BIT_SHORT]  = shortDetectEnable && refShortDetect;
    if (readHit) begin
      clrVec = '1;
      // Latched short value is frozen while detection is off
      clrVec[SFS_BIT_SHORT] = shortDetectEnable;
    end
    flags_next = (flags_reg & ~clrVec) | setVec;
  end

  // Snapshot returned to the host on a read
  always_comb begin
    rdata_next = rdata_reg;
    if (readHit) begin
      rdata_next = {SFS_RSVD_VALUE, flags_reg};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= SFS_FLAGS_RESET[SFS_FLAG_W-1:0];
      rdata_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs seen by the rest of the device
  assign flagsOut     = {SFS_RSVD_VALUE, flags_reg};
  assign readData     = rdata_reg;
  assign summaryFault = |(flags_reg & ~faultMask);
  // Live level used so the parts restart as soon as it cools
  assign shutdownAll  = overTemp;
  // Open pin alone never disables channels
  assign channelsDisable = overTemp || (shortDetectEnable && refShortDetect);

  // Checks of the block's own behaviour

  undervolt_set_a: assert property (
    @(posedge clock) disable iff (!resetn)
    supplyAUnder |=> flags_reg[SFS_BIT_UNDERV])
    else $error("undervoltage flag not set");

  addr_len_a: assert property (
    @(posedge clock) disable iff (!resetn)
    frameEnd && !daisyChain && (groups_reg == SFS_GROUP_MANY) |-> !countOk)
    else $error("overlong addressable frame accepted");

  daisy_len_a: assert property (
    @(posedge clock) disable iff (!resetn)
    frameEnd && daisyChain && (phase_reg != 5'h00) |-> !countOk)
    else $error("partial daisy frame accepted");

  clkerr_set_a: assert property (
    @(posedge clock) disable iff (!resetn)
    frameEnd && !countOk && !overTemp |=> flags_reg[SFS_BIT_CLKERR])
    else $error("clock count error not flagged");

  bad_drop_a: assert property (
    @(posedge clock) disable iff (!resetn)
    cmdValid && frameEnd && !countOk |-> !cmdAccept ##1 $stable(readData))
    else $error("bad frame command acted on");

  shutdown_off_a: assert property (
    @(posedge clock) disable iff (!resetn)
    overTemp |-> shutdownAll && channelsDisable && !cmdAccept
      ##1 flags_reg[SFS_BIT_OTEMP])
    else $error("thermal shutdown not applied");

  open_only_a: assert property (
    @(posedge clock) disable iff (!resetn)
    refOpenDetect && !overTemp && !refShortDetect |-> !channelsDisable
      ##1 flags_reg[SFS_BIT_OPEN])
    else $error("open pin touched channels");

  open_shdn_a: assert property (
    @(posedge clock) disable iff (!resetn)
    overTemp |=> flags_reg[SFS_BIT_OPEN])
    else $error("open flag low in shutdown");

  short_hold_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !shortDetectEnable |=> flags_reg[SFS_BIT_SHORT] == $past(flags_reg[SFS_BIT_SHORT]))
    else $error("short flag moved while disabled");

  short_dis_a: assert property (
    @(posedge clock) disable iff (!resetn)
    shortDetectEnable && refShortDetect |-> channelsDisable
      ##1 flags_reg[SFS_BIT_SHORT])
    else $error("short did not disable channels");

  summary_or_a: assert property (
    @(posedge clock) disable iff (!resetn)
    flags_reg[SFS_BIT_UNDERV] && !faultMask[SFS_BIT_UNDERV] |-> summaryFault)
    else $error("summary missed unmasked flag");

  read_clear_a: assert property (
    @(posedge clock) disable iff (!resetn)
    readHit && !supplyAUnder && !refOpenDetect && shortDetectEnable
      && !refShortDetect |=> flags_reg == '0 && !summaryFault)
    else $error("read did not clear flags");

  reset_again_a: assert property (
    @(posedge clock) disable iff (!resetn)
    readHit && supplyAUnder |=> flags_reg[SFS_BIT_UNDERV] ##1 readData[SFS_BIT_UNDERV] == $past(readData[SFS_BIT_UNDERV]))
    else $error("lasting fault not set again");

  reserved_zero_a: assert property (
    @(posedge clock) disable iff (!resetn)
    readHit |=> readData[7:5] == SFS_RSVD_VALUE)
    else $error("reserved bits not zero");

  // Main scenarios
  good_read_c: cover property (
    @(posedge clock) disable iff (!resetn) readHit);

  bad_frame_c: cover property (
    @(posedge clock) disable iff (!resetn) frameEnd && !countOk);

  daisy_ok_c: cover property (
    @(posedge clock) disable iff (!resetn)
    frameEnd && daisyChain && countOk && groups_reg == SFS_GROUP_MANY);

  short_hold_c: cover property (
    @(posedge clock) disable iff (!resetn)
    !shortDetectEnable && flags_reg[SFS_BIT_SHORT] && readHit);

endmodule : sfs_secondary_fault_status

`default_nettype wire

// [sfs_pkg.sv]
// Constants for the secondary fault status block.
// Assumes one 40 MHz system clock; SPI pins sampled in that domain.
package sfs_pkg;

  // Register placement on the SPI register map
  localparam int          SFS_ADDR_W      = 8;
  localparam logic [7:0]  SFS_FLAGS_OFFSET = 8'h0D;

  // Field positions inside the flags register
  localparam int          SFS_BIT_SHORT   = 0;
  localparam int          SFS_BIT_OPEN    = 1;
  localparam int          SFS_BIT_OTEMP   = 2;
  localparam int          SFS_BIT_CLKERR  = 3;
  localparam int          SFS_BIT_UNDERV  = 4;
  localparam int          SFS_FLAG_W      = 5;
  localparam int          SFS_REG_W       = 8;

  // Reset value: undervoltage flag set, all else clear
  localparam logic [7:0]  SFS_FLAGS_RESET = 8'h10;
  localparam logic [2:0]  SFS_RSVD_VALUE  = 3'h0;

  // Frame lengths in serial clock cycles
  localparam logic [4:0]  SFS_LEN_CRC     = 5'h18;
  localparam logic [4:0]  SFS_LEN_NOCRC   = 5'h10;

  // Whole-length group counter saturates here
  localparam logic [1:0]  SFS_GROUP_MANY  = 2'h2;
  localparam logic [1:0]  SFS_GROUP_ONE   = 2'h1;

endpackage : sfs_pkg

// [sfs_spi_host.sv]
// SPI host model: selects, clocks a set count, releases with a command.
// Assumes the bench calls frame() with no other frame in flight.
`timescale 1ns/1ps
`default_nettype none
module sfs_spi_host (
  input  wire logic       clock,
  output logic            spiSclk,
  output logic            spiCsN,
  output logic            cmdValid,
  output logic            cmdRead,
  output logic [7:0]      cmdAddr
);
  // Idle: deselected, clock parked low
  initial begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdAddr = 8'h00;
  end
  // Phase length ph gives a prompt or slow serial clock
  task automatic frame(input int n, input logic rd, input logic [7:0] addr, input int ph);
    @(posedge clock) #1 spiCsN = 1'b0;
    repeat (n) begin
      repeat (ph) @(posedge clock);
      #1 spiSclk = 1'b1;
      repeat (ph) @(posedge clock);
      #1 spiSclk = 1'b0;
    end
    @(posedge clock) #1 spiCsN = 1'b1;
    cmdValid = 1'b1;
    cmdRead = rd;
    cmdAddr = addr;
    // Stale command fields are scrambled once the command is gone
    @(posedge clock) #1 cmdValid = 1'b0;
    cmdRead = ~rd;
    cmdAddr = ~addr;
  endtask : frame
endmodule : sfs_spi_host
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the secondary fault status block.
// Assumes sfs_spi_host drives every frame and command.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sfs_pkg::*;
;
  typedef struct {logic dc; logic crc; int n; logic ok;} sfs_row_type;
  logic clock = 0, resetn = 0, daisyChain = 0, crcEnable = 0, shortDetectEnable = 0;
  logic supplyAUnder = 0, overTemp = 0, refOpenDetect = 0, refShortDetect = 0, accSeen = 0;
  logic [4:0] faultMask = 5'h00;
  logic spiSclk, spiCsN, cmdValid, cmdRead, cmdAccept, summaryFault, shutdownAll, channelsDisable;
  logic [7:0] cmdAddr, flagsOut, readData, expF, expR;
  int errors = 0, cmpCount = 0, cyc = 0;
  // Mode, CRC, clock count, expected acceptance
  sfs_row_type rows[12] = '{'{0,0,16,1}, '{0,0,15,0}, '{0,0,16,1}, '{0,1,24,1}, '{0,1,16,0},
    '{0,0,17,0}, '{1,0,32,1}, '{1,0,24,0}, '{1,1,48,1}, '{1,1,0,0}, '{1,1,24,1}, '{0,1,48,0}};

  sfs_secondary_fault_status sfs_secondary_fault_status_inst (.clock, .resetn, .spiSclk, .spiCsN,
    .daisyChain, .crcEnable, .shortDetectEnable, .faultMask, .cmdValid, .cmdRead, .cmdAddr,
    .supplyAUnder, .overTemp, .refOpenDetect, .refShortDetect, .cmdAccept, .flagsOut, .readData,
    .summaryFault, .shutdownAll, .channelsDisable);
  sfs_spi_host sfs_spi_host_inst (.clock, .spiSclk, .spiCsN, .cmdValid, .cmdRead, .cmdAddr);

  always #12.5 clock = ~clock;
  // Accept is a one-cycle pulse, so latch it for later checking
  always @(posedge clock) if (cmdAccept) accSeen <= 1'b1;
  // Hang guard, well above the longest expected run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      testDone();
    end
  end

  task automatic testDone();
    $display("comparisons %0d mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : testDone
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkByte
  task automatic chkBit(input logic got, input logic exp);
    chkByte({7'h00, got}, {7'h00, exp});
  endtask : chkBit
  // Legal 16-clock read of the flags register
  task automatic rdReg();
    accSeen = 1'b0;
    sfs_spi_host_inst.frame(16, 1'b1, SFS_FLAGS_OFFSET, 1);
  endtask : rdReg
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  initial begin
    repeat (20) @(posedge clock);
    #1 resetn = 1'b1;
    chkByte(flagsOut, 8'h10);
    chkByte(readData, 8'h00);
    chkBit(summaryFault, 1'b1);
    expF = 8'h10;
    expR = 8'h00;
    // Frame length table; bad frames must not read or clear
    foreach (rows[i]) begin
      daisyChain = rows[i].dc;
      crcEnable = rows[i].crc;
      accSeen = 1'b0;
      sfs_spi_host_inst.frame(rows[i].n, 1'b1, SFS_FLAGS_OFFSET, 1 + i % 2);
      chkBit(accSeen, rows[i].ok);
      if (rows[i].ok) begin
        expR = expF;
        expF = 8'h00;
      end
      else expF[3] = 1'b1;
      chkByte(readData, expR);
      chkByte(flagsOut, expF);
    end
    $display("frame table done");
    daisyChain = 1'b0;
    crcEnable = 1'b0;
    // Lasting undervoltage survives a read; mask gates the summary;
    // clock error from the last table row is still pending here
    supplyAUnder = 1'b1;
    settle();
    rdReg();
    chkByte(readData, 8'h18);
    chkByte(flagsOut, 8'h10);
    faultMask = 5'h10;
    #1 chkBit(summaryFault, 1'b0);
    supplyAUnder = 1'b0;
    // Legal frames that are not a read of this register leave it alone
    accSeen = 1'b0;
    sfs_spi_host_inst.frame(16, 1'b0, SFS_FLAGS_OFFSET, 1);
    chkBit(accSeen, 1'b1);
    chkByte(flagsOut, 8'h10);
    accSeen = 1'b0;
    sfs_spi_host_inst.frame(16, 1'b1, SFS_FLAGS_OFFSET + 8'h01, 2);
    chkBit(accSeen, 1'b1);
    chkByte(readData, 8'h18);
    rdReg();
    chkByte(flagsOut, 8'h00);
    $display("undervoltage done");
    // Thermal shutdown: outputs off, open flag forced, SPI ignored
    overTemp = 1'b1;
    settle();
    chkBit(shutdownAll, 1'b1);
    chkBit(channelsDisable, 1'b1);
    chkByte(flagsOut, 8'h06);
    accSeen = 1'b0;
    sfs_spi_host_inst.frame(15, 1'b1, SFS_FLAGS_OFFSET, 1);
    chkBit(accSeen, 1'b0);
    chkByte(flagsOut, 8'h06);
    overTemp = 1'b0;
    rdReg();
    chkByte(readData, 8'h06);
    $display("shutdown done");
    // Open pin only flags, channels keep running
    refOpenDetect = 1'b1;
    settle();
    chkByte(flagsOut, 8'h02);
    chkBit(channelsDisable, 1'b0);
    refOpenDetect = 1'b0;
    rdReg();
    // Short detection gated by its enable, latched when disabled
    refShortDetect = 1'b1;
    settle();
    chkByte(flagsOut, 8'h00);
    chkBit(channelsDisable, 1'b0);
    shortDetectEnable = 1'b1;
    settle();
    chkByte(flagsOut, 8'h01);
    chkBit(channelsDisable, 1'b1);
    // Read with detection on clears the short flag once the short is gone
    refShortDetect = 1'b0;
    rdReg();
    chkByte(readData, 8'h01);
    chkByte(flagsOut, 8'h00);
    chkBit(channelsDisable, 1'b0);
    refShortDetect = 1'b1;
    settle();
    shortDetectEnable = 1'b0;
    refShortDetect = 1'b0;
    rdReg();
    chkByte(readData, 8'h01);
    chkByte(flagsOut, 8'h01);
    $display("reference pin done");
    testDone();
  end
endmodule : testbench
`default_nettype wire
